// File: verilog/sfid_pkg.sv
/*
 * Shared constants and types of the serial flash instruction decoder:
 * opcodes, frame lengths, status layout and the status-write timing.
 * Assumes a 40 MHz core clock; the figures below are derived from it.
 */
`default_nettype none
package sfid_pkg;
   localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_STATUS_READ   = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
   localparam logic [7:0] OP_PAGE_PROGRAM  = 8'h02;
   localparam logic [7:0] OP_SECTOR_ERASE  = 8'h20;
   localparam logic [7:0] OP_BLOCK_ERASE   = 8'hd8;
   localparam logic [7:0] OP_CHIP_ERASE_A  = 8'hc7;
   localparam logic [7:0] OP_CHIP_ERASE_B  = 8'h60;
   localparam logic [7:0] OP_READ          = 8'h03;
   localparam logic [7:0] OP_FAST_READ     = 8'h0b;
   localparam logic [7:0] OP_READ_ID       = 8'hab;
   localparam logic [7:0] OP_ENTER_OTP     = 8'h3a;

   // frame lengths in whole bytes, opcode included
   localparam logic [3:0] LEN_CMD    = 4'h1;
   localparam logic [3:0] LEN_ADDR   = 4'h4;
   localparam logic [3:0] LEN_PP_MIN = 4'h5;
   localparam logic [3:0] LEN_WSR_A  = 4'h2;
   localparam logic [3:0] LEN_WSR_B  = 4'h3;
   localparam logic [3:0] BCNT_MAX   = 4'hf;
   // bytes after the opcode before output or data starts
   localparam logic [3:0] HDR_ADDR   = 4'h3;
   localparam logic [3:0] HDR_FAST   = 4'h4;
   localparam logic [3:0] HDR_ID     = 4'h3;

   localparam logic [7:0] DEV_ID_DEFAULT = 8'h5a; // arbitrary value
   localparam logic [2:0] BP_RESET   = 3'h0;
   localparam logic       LOCK_RESET = 1'b0;

   localparam int CORE_CLK_MHZ = 40;
   localparam int T_W_US       = 10000;
   localparam int TW_CYCLES    = T_W_US * CORE_CLK_MHZ;
   localparam int TMR_W        = 19;

   typedef enum logic [2:0] {
      PH_OP   = 3'b000,
      PH_ARGS = 3'b001,
      PH_OUT  = 3'b010,
      PH_DATA = 3'b011,
      PH_DONE = 3'b100,
      PH_IGN  = 3'b101
   } sfid_phase_t;

   typedef struct packed {
      logic       lock;
      logic [1:0] rsv;
      logic [2:0] bp;
      logic       wlatch;
      logic       busy;
   } sfid_status_t;

   typedef struct packed {
      logic        seq;
      logic [7:0]  opcode;
      logic [3:0]  bytes;
      logic        whole;
      logic [23:0] addr;
      logic [7:0]  wdata;
   } sfid_frame_t;
endpackage : sfid_pkg
`default_nettype wire

// File: verilog/sfid_sync.sv
/*
 * Two-flop level synchroniser, one stage pair per bit.
 * Assumes the input bits are levels that change slowly against clk.
 */
`timescale 1ns/100ps
`default_nettype none
module sfid_sync
#(
   parameter int         W   = 1,
   parameter logic [W-1:0] RST = '0
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r <= RST;
         q      <= RST;
      end
      else
      begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : sfid_sync
`default_nettype wire

// File: verilog/sfid_wtimer.sv
/*
 * Self-timed cycle counter: a start pulse loads the length, done pulses
 * once when it has run out. Assumes start never comes while running.
 */
`timescale 1ns/100ps
`default_nettype none
module sfid_wtimer
   import sfid_pkg::*;
#(
   parameter int CYCLES = TW_CYCLES
)
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic start,
   output var  logic done
);
   logic [TMR_W-1:0] cnt_r;
   logic             run_r;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_r <= '0;
         run_r <= 1'b0;
         done  <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start)
         begin
            cnt_r <= TMR_W'(CYCLES - 1);
            run_r <= 1'b1;
         end
         else if (run_r)
         begin
            if (cnt_r == '0)
            begin
               run_r <= 1'b0;
               done  <= 1'b1;
            end
            else
               cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule : sfid_wtimer
`default_nettype wire

// File: verilog/sfid_top.sv
/*
 * Serial flash instruction decoder: frames and decodes host instructions
 * on the serial clock, executes them in the core clock domain.
 * Assumes chip select stays high for at least four core clocks between
 * frames, an array read port that answers combinationally, and an
 * external engine that runs program and erase and pulses op_done.
 */
// Notes on behaviour
// - chip select falling starts; first byte opcode
// - sample input on rising clock, MSB first
// - chip select rising ends; output stops cleanly
// - write-class needs whole bytes or discarded
// - busy ignores all but status read
// - write enable opcode sets write latch
// - write-class accepted only with latch set
// - write disable clears latch and OTP
// - latch clears at reset and cycle end
// - status read shifts status out, falling edge
// - status read anytime, repeats current value
// - status write changes only lock, protect bits
// - status write ends at bit 16 or 24
// - status write runs timed busy cycle
// - read takes 24-bit address, outputs byte
// - read address increments per output byte
// - read while busy is ignored entirely
// - page program wraps offset within page
// - output driven only in response fields
// - ID read: three dummies, then repeating code
// - fast read adds one dummy byte
// - sector erase takes address, needs latch
// - block erase takes address, needs latch
// - chip erase single byte, two opcodes
`timescale 1ns/100ps
`default_nettype none
module sfid_top
   import sfid_pkg::*;
#(
   parameter int         TW     = TW_CYCLES,
   parameter logic [7:0] DEV_ID = DEV_ID_DEFAULT
)
(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        serial_input,
   output var  logic        serial_output,
   output var  logic        serial_output_oe,
   output var  logic [23:0] arr_rd_addr,
   input  wire logic [7:0]  arr_rd_data,
   output var  logic        pgm_we,
   output var  logic [7:0]  pgm_offset,
   output var  logic [7:0]  pgm_data,
   output var  logic        op_start,
   output var  logic [7:0]  op_code,
   output var  logic [23:0] op_addr,
   input  wire logic        op_done,
   output var  logic [7:0]  status_byte,
   output var  logic        otp_mode
);
   // link side: reset by power-up and by every deselect, except the status sample and frame summary
   logic         link_rst_n;
   logic [2:0]   bit_r;
   logic [3:0]   bcnt_r;
   logic [3:0]   bcnt_nxt;
   logic [6:0]   sh_r;
   logic [7:0]   byte_v;
   logic         byte_done;
   logic         first_edge;
   sfid_phase_t  phase_r;
   sfid_phase_t  after_r;
   logic [3:0]   hdr_r;
   logic         incr_r;
   logic [23:0]  addr_r;
   logic [7:0]   off_r;
   logic         out_act_r;
   logic         so_r;
   logic [6:0]   osr_r;
   logic [2:0]   nbit_r;
   logic [7:0]   out_byte;
   logic [7:0]   status_lk;
   logic [7:0]   st_prev_r;
   logic [7:0]   st_ok_r;
   sfid_status_t st_lk;
   sfid_frame_t  fr_r;

   assign link_rst_n = rst_n & ~cs_n;
   assign byte_done  = (bit_r == 3'h7);
   assign byte_v     = {sh_r, serial_input};
   assign first_edge = (bit_r == 3'h0) && (bcnt_r == 4'h0);
   assign bcnt_nxt   = (bcnt_r == BCNT_MAX) ? BCNT_MAX : bcnt_r + 4'h1;
   assign st_lk      = sfid_status_t'(st_ok_r);

   sfid_sync #(.W(8), .RST(8'h00)) u_st_sync
   (
      .clk   (sclk),
      .rst_n (rst_n),
      .d     (status_byte),
      .q     (status_lk)
   );

   // the status word crosses as a whole; take it only once two samples
   // agree, so a torn mix of old and new bits never reaches the output
   always_ff @(posedge sclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_prev_r <= 8'h00;
         st_ok_r   <= 8'h00;
      end
      else
      begin
         st_prev_r <= status_lk;
         if (status_lk == st_prev_r)
            st_ok_r <= status_lk;
      end
   end

   always_ff @(posedge sclk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         bit_r  <= 3'h0;
         bcnt_r <= 4'h0;
         sh_r   <= 7'h00;
      end
      else
      begin
         bit_r <= bit_r + 3'h1;
         sh_r  <= byte_v[6:0];
         if (byte_done)
            bcnt_r <= bcnt_nxt;
      end
   end

   // instruction phase on the link; the opcode picks the header length
   always_ff @(posedge sclk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         phase_r   <= PH_OP;
         after_r   <= PH_DONE;
         hdr_r     <= 4'h0;
         incr_r    <= 1'b0;
         out_act_r <= 1'b0;
      end
      else if (byte_done)
      begin
         case (phase_r)
            PH_OP:
            begin
               if (st_lk.busy && byte_v != OP_STATUS_READ)
                  phase_r <= PH_IGN;
               else if (byte_v == OP_STATUS_READ)
               begin
                  phase_r   <= PH_OUT;
                  out_act_r <= 1'b1;
               end
               else if (byte_v == OP_READ)
               begin
                  phase_r <= PH_ARGS;
                  after_r <= PH_OUT;
                  hdr_r   <= HDR_ADDR;
                  incr_r  <= 1'b1;
               end
               else if (byte_v == OP_FAST_READ)
               begin
                  phase_r <= PH_ARGS;
                  after_r <= PH_OUT;
                  hdr_r   <= HDR_FAST;
                  incr_r  <= 1'b1;
               end
               else if (byte_v == OP_READ_ID)
               begin
                  phase_r <= PH_ARGS;
                  after_r <= PH_OUT;
                  hdr_r   <= HDR_ID;
               end
               else if (byte_v == OP_PAGE_PROGRAM)
               begin
                  phase_r <= PH_ARGS;
                  after_r <= PH_DATA;
                  hdr_r   <= HDR_ADDR;
               end
               else if (byte_v == OP_SECTOR_ERASE || byte_v == OP_BLOCK_ERASE)
               begin
                  phase_r <= PH_ARGS;
                  after_r <= PH_DONE;
                  hdr_r   <= HDR_ADDR;
               end
               else if (byte_v == OP_WRITE_ENABLE || byte_v == OP_WRITE_DISABLE ||
                        byte_v == OP_STATUS_WRITE || byte_v == OP_CHIP_ERASE_A ||
                        byte_v == OP_CHIP_ERASE_B || byte_v == OP_ENTER_OTP)
                  phase_r <= PH_DONE;
               else
                  phase_r <= PH_IGN;
            end
            PH_ARGS:
            begin
               if (bcnt_r == hdr_r)
               begin
                  phase_r   <= after_r;
                  out_act_r <= (after_r == PH_OUT);
               end
            end
            default:
            begin
               phase_r <= phase_r;
            end
         endcase
      end
   end

   // read address: loaded from the header, stepped per output byte
   always_ff @(posedge sclk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         addr_r <= 24'h000000;
         off_r  <= 8'h00;
      end
      else if (byte_done)
      begin
         if (phase_r == PH_ARGS && bcnt_r <= HDR_ADDR)
            addr_r <= {addr_r[15:0], byte_v};
         else if (phase_r == PH_OUT && incr_r)
            addr_r <= addr_r + 24'h000001;
         if (phase_r == PH_ARGS && bcnt_r == HDR_ADDR)
            off_r <= byte_v;
         else if (phase_r == PH_DATA)
            off_r <= off_r + 8'h01;
      end
   end

   // page data goes out a byte at a time; offset wraps inside the page
   always_ff @(posedge sclk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         pgm_we     <= 1'b0;
         pgm_offset <= 8'h00;
         pgm_data   <= 8'h00;
      end
      else
      begin
         pgm_we <= byte_done && phase_r == PH_DATA;
         if (byte_done && phase_r == PH_DATA)
         begin
            pgm_offset <= off_r;
            pgm_data   <= byte_v;
         end
      end
   end

   // frame summary survives the deselect so the core can judge it;
   // the seq toggle tells a fresh frame from a stale one
   always_ff @(posedge sclk or negedge rst_n)
   begin
      if (!rst_n)
         fr_r <= '0;
      else
      begin
         fr_r.whole <= byte_done;
         if (first_edge)
         begin
            fr_r.seq   <= ~fr_r.seq;
            fr_r.bytes <= 4'h0;
         end
         else if (byte_done)
            fr_r.bytes <= bcnt_nxt;
         if (byte_done && bcnt_r == 4'h0)
            fr_r.opcode <= byte_v;
         if (byte_done && bcnt_r == 4'h1)
            fr_r.wdata <= byte_v;
         if (byte_done && phase_r == PH_ARGS && bcnt_r == HDR_ADDR)
            fr_r.addr <= {addr_r[15:0], byte_v};
      end
   end

   always_comb
   begin
      if (fr_r.opcode == OP_STATUS_READ)
         out_byte = st_ok_r;
      else if (fr_r.opcode == OP_READ_ID)
         out_byte = DEV_ID;
      else
         out_byte = arr_rd_data;
   end

   // output shifts on the falling edge, a new byte every eighth edge
   always_ff @(negedge sclk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         so_r   <= 1'b0;
         osr_r  <= 7'h00;
         nbit_r <= 3'h0;
      end
      else if (out_act_r)
      begin
         if (nbit_r == 3'h0)
         begin
            so_r  <= out_byte[7];
            osr_r <= out_byte[6:0];
         end
         else
         begin
            so_r  <= osr_r[6];
            osr_r <= {osr_r[5:0], 1'b0};
         end
         nbit_r <= nbit_r + 3'h1;
      end
   end

   assign serial_output    = so_r;
   assign serial_output_oe = out_act_r;
   assign arr_rd_addr      = addr_r;

   a_read_step: assert property (@(posedge sclk) disable iff (!link_rst_n)
      (byte_done && phase_r == PH_OUT && incr_r) |=> addr_r == $past(addr_r) + 24'h1)
      else $error("read address did not step");
   a_ign_quiet: assert property (@(posedge sclk) disable iff (!link_rst_n)
      (phase_r == PH_IGN) |-> !out_act_r)
      else $error("output driven on ignored opcode");

   // core side: judge each frame once chip select is seen high
   logic         cs_s;
   logic         cs_d_r;
   logic         seq_seen_r;
   logic         frame_end;
   logic         go;
   logic         len_one;
   logic         wr_op;
   logic         exec_write_enable_opcode;
   logic         exec_write_disable_opcode;
   logic         exec_otp;
   logic         exec_wsr;
   logic         exec_op;
   logic         work_done;
   logic         tmr_done;
   logic         wsr_run_r;
   logic         wlatch_r;
   logic         busy_r;
   logic [2:0]   bp_r;
   logic         lock_r;
   sfid_status_t st_core;

   sfid_sync #(.W(1), .RST(1'b1)) u_cs_sync
   (
      .clk   (core_clk),
      .rst_n (rst_n),
      .d     (cs_n),
      .q     (cs_s)
   );

   sfid_wtimer #(.CYCLES(TW)) u_wtimer
   (
      .clk   (core_clk),
      .rst_n (rst_n),
      .start (exec_wsr),
      .done  (tmr_done)
   );

   assign frame_end = cs_s & ~cs_d_r;
   assign go        = frame_end && (fr_r.seq != seq_seen_r) && !busy_r;
   assign len_one   = fr_r.whole && fr_r.bytes == LEN_CMD;
   assign exec_write_enable_opcode = go && fr_r.opcode == OP_WRITE_ENABLE && len_one;
   assign exec_write_disable_opcode = go && fr_r.opcode == OP_WRITE_DISABLE && len_one;
   assign exec_otp  = go && fr_r.opcode == OP_ENTER_OTP && len_one;
   assign exec_wsr  = go && wlatch_r && fr_r.opcode == OP_STATUS_WRITE && fr_r.whole &&
                      (fr_r.bytes == LEN_WSR_A || fr_r.bytes == LEN_WSR_B);

   always_comb
   begin
      if (fr_r.opcode == OP_PAGE_PROGRAM)
         wr_op = fr_r.bytes >= LEN_PP_MIN;
      else if (fr_r.opcode == OP_SECTOR_ERASE || fr_r.opcode == OP_BLOCK_ERASE)
         wr_op = fr_r.bytes == LEN_ADDR;
      else if (fr_r.opcode == OP_CHIP_ERASE_A || fr_r.opcode == OP_CHIP_ERASE_B)
         wr_op = fr_r.bytes == LEN_CMD;
      else
         wr_op = 1'b0;
   end

   assign exec_op   = go && wlatch_r && fr_r.whole && wr_op;
   assign work_done = busy_r && (wsr_run_r ? tmr_done : op_done);

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cs_d_r     <= 1'b1;
         seq_seen_r <= 1'b0;
      end
      else
      begin
         cs_d_r <= cs_s;
         if (frame_end)
            seq_seen_r <= fr_r.seq;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         wlatch_r <= 1'b0;
      else if (exec_write_enable_opcode)
         wlatch_r <= 1'b1;
      else if (exec_write_disable_opcode || work_done)
         wlatch_r <= 1'b0;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy_r    <= 1'b0;
         wsr_run_r <= 1'b0;
      end
      else if (exec_wsr || exec_op)
      begin
         busy_r    <= 1'b1;
         wsr_run_r <= exec_wsr;
      end
      else if (work_done)
         busy_r <= 1'b0;
   end

   // lock and protect bits stand for the nonvolatile cells
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bp_r   <= BP_RESET;
         lock_r <= LOCK_RESET;
      end
      else if (exec_wsr)
      begin
         if (otp_mode)
            lock_r <= 1'b1;
         else
         begin
            lock_r <= fr_r.wdata[7];
            bp_r   <= fr_r.wdata[4:2];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         otp_mode <= 1'b0;
      else if (exec_otp)
         otp_mode <= 1'b1;
      else if (exec_write_disable_opcode)
         otp_mode <= 1'b0;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         op_start <= 1'b0;
         op_code  <= 8'h00;
         op_addr  <= 24'h000000;
      end
      else
      begin
         op_start <= exec_op;
         if (exec_op)
         begin
            op_code <= fr_r.opcode;
            op_addr <= fr_r.addr;
         end
      end
   end

   always_comb
   begin
      st_core        = '0;
      st_core.lock   = lock_r;
      st_core.bp     = bp_r;
      st_core.wlatch = wlatch_r;
      st_core.busy   = busy_r;
   end

   assign status_byte = st_core;

   a_write_enable_opcode_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
      exec_write_enable_opcode |=> wlatch_r)
      else $error("write enable did not set latch");
   a_write_disable_opcode_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
      exec_write_disable_opcode |=> !wlatch_r && !otp_mode)
      else $error("write disable did not clear");
   a_wsr_gated: assert property (@(posedge core_clk) disable iff (!rst_n)
      (exec_wsr || exec_op) |-> wlatch_r && !busy_r)
      else $error("write class without latch");
   a_wsr_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
      exec_wsr |=> busy_r [*8])
      else $error("status write cycle not busy");
   a_done_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
      work_done |=> !busy_r && !wlatch_r)
      else $error("cycle end left busy or latch");
   a_busy_ignores: assert property (@(posedge core_clk) disable iff (!rst_n)
      (busy_r && !work_done) |=> $stable(wlatch_r) && $stable(bp_r) && !op_start)
      else $error("instruction acted on while busy");
   a_part_byte: assert property (@(posedge core_clk) disable iff (!rst_n)
      (frame_end && !fr_r.whole && !busy_r) |=> !busy_r && !op_start)
      else $error("partial byte frame executed");
   a_ro_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
      exec_wsr |=> status_byte[6:5] == 2'h0 && wlatch_r == $past(wlatch_r))
      else $error("status write touched read-only bits");
endmodule : sfid_top
`default_nettype wire

// File: sim/sfid_host.sv
/*
 * Host serial controller model, mode 0, frames driven by tasks.
 * Assumes the device shifts out on falling sclk; link period 125 ns.
 */
`timescale 1ns/100ps
`default_nettype none
module sfid_host
(
   output var  logic sclk,
   output var  logic cs_n,
   output var  logic serial_input,
   input  wire logic serial_output
);
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      serial_input = 1'b0;
   end
   task start;
      cs_n = 1'b0;
      #62.5;
   endtask : start
   // sample at the rise, half a period after the device shifted
   task xbit(input logic b, output logic r);
      serial_input = b;
      #62.5 sclk = 1'b1;
      r = serial_output;
      #62.5 sclk = 1'b0;
   endtask : xbit
   task xbyte(input logic [7:0] d, output logic [7:0] q);
      for (int i = 7; i >= 0; i--)
         xbit(d[i], q[i]);
   endtask : xbyte
   // released input flips so a stale bit never looks valid
   task stop;
      #62.5 cs_n = 1'b1;
      serial_input = ~serial_input;
      #250;
   endtask : stop
endmodule : sfid_host
`default_nettype wire

// File: sim/sfid_top_test.sv
/*
 * Self-checking bench of the instruction decoder with a host model.
 * Assumes a short status-write time and a combinational array model.
 */
`timescale 1ns/100ps
`default_nettype none
module sfid_top_test
   import sfid_pkg::*;
;
   localparam logic [7:0] ID = 8'h3c; // arbitrary value
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        sclk, cs_n, serial_input, serial_output, serial_output_oe;
   logic        pgm_we, op_start, op_done, otp_mode, oe_seen, b;
   logic [23:0] arr_rd_addr, op_addr;
   logic [7:0]  arr_rd_data, pgm_offset, pgm_data, op_code, status_byte;
   logic [7:0]  rx, last_off, last_dat;
   logic [7:0]  st_cnt = 8'h00;
   int          error_cnt = 0;
   int          cmp_count = 0;

   always #12.5 core_clk = ~core_clk;
   assign arr_rd_data = arr_rd_addr[7:0] ^ 8'ha5;
   sfid_top #(.TW(2000), .DEV_ID(ID)) sfid_top_inst (.core_clk, .rst_n, .sclk, .cs_n,
      .serial_input, .serial_output, .serial_output_oe, .arr_rd_addr, .arr_rd_data, .pgm_we,
      .pgm_offset, .pgm_data, .op_start, .op_code, .op_addr, .op_done, .status_byte, .otp_mode);
   sfid_host sfid_host_inst (.sclk, .cs_n, .serial_input, .serial_output);

   always @(posedge sclk) if (serial_output_oe === 1'b1) oe_seen = 1'b1;
   always @(negedge sclk)
      if (pgm_we === 1'b1)
      begin
         last_off = pgm_offset;
         last_dat = pgm_data;
      end
   always @(posedge core_clk) if (op_start === 1'b1) st_cnt++;

   task conclude;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude
   task chk(input string n, input logic [7:0] e, input logic [7:0] s);
      cmp_count++;
      if (s !== e)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task cmd(input logic [7:0] c, input int nb, input int nx);
      sfid_host_inst.start;
      sfid_host_inst.xbyte(c, rx);
      repeat (nb) sfid_host_inst.xbyte(8'hfc, rx);
      repeat (nx) sfid_host_inst.xbit(1'b1, b);
      sfid_host_inst.stop;
   endtask : cmd
   task wait_idle;
      int n;
      n = 0;
      while (status_byte[0] !== 1'b0 && n < 4000)
      begin
         @(negedge core_clk);
         n++;
      end
      if (n == 4000)
      begin
         error_cnt++;
         conclude;
      end
   endtask : wait_idle
   // two output bytes, then a cut in mid byte
   task rd(input logic [7:0] c, input int nh, input logic [7:0] a, e0, e1);
      sfid_host_inst.start;
      sfid_host_inst.xbyte(c, rx);
      repeat (nh) sfid_host_inst.xbyte(a, rx);
      sfid_host_inst.xbyte(8'h00, rx);
      chk("byte0", e0, rx);
      sfid_host_inst.xbyte(8'h00, rx);
      chk("byte1", e1, rx);
      repeat (3) sfid_host_inst.xbit(1'b0, b);
      sfid_host_inst.stop;
      chk("oe_end", 8'h00, {7'h00, serial_output_oe});
   endtask : rd
   task er(input logic [7:0] c, input int nb, nx, input logic en, input logic [7:0] n);
      logic [7:0] s0;
      if (en) cmd(OP_WRITE_ENABLE, 0, 0);
      s0 = st_cnt;
      cmd(c, nb, nx);
      chk("starts", n, st_cnt);
      if (n != s0) chk("opcode", c, op_code);
      @(negedge core_clk) op_done = 1'b1;
      @(negedge core_clk) op_done = 1'b0;
      wait_idle;
      chk("after", (en && n == s0) ? 8'h9e : 8'h9c, status_byte);
   endtask : er

   task t_status_write;
      cmd(OP_WRITE_ENABLE, 0, 0);
      rd(OP_STATUS_READ, 0, 8'h00, 8'h02, 8'h02);
      cmd(OP_STATUS_WRITE, 1, 0);
      chk("wsr_busy", 8'h9f, status_byte);
      rd(OP_STATUS_READ, 0, 8'h00, 8'h9f, 8'h9f);
      oe_seen = 1'b0;
      cmd(OP_READ, 4, 0);
      chk("busy_read", 8'h00, {7'h00, oe_seen});
      wait_idle;
      chk("wsr_end", 8'h9c, status_byte);
      cmd(OP_WRITE_ENABLE, 0, 0);
      cmd(OP_STATUS_WRITE, 1, 4);
      chk("wsr_part", 8'h9e, status_byte);
      cmd(OP_WRITE_DISABLE, 0, 0);
      chk("write_disable_opcode", 8'h9c, status_byte);
      cmd(OP_ENTER_OTP, 0, 0);
      chk("otp_on", 8'h01, {7'h00, otp_mode});
      cmd(OP_WRITE_DISABLE, 0, 0);
      chk("otp_off", 8'h00, {7'h00, otp_mode});
   endtask : t_status_write
   task t_reads;
      rd(OP_READ, 3, 8'hfe, 8'hfe ^ 8'ha5, 8'hff ^ 8'ha5);
      rd(OP_FAST_READ, 4, 8'h10, 8'h10 ^ 8'ha5, 8'h11 ^ 8'ha5);
      rd(OP_READ_ID, 3, 8'h33, ID, ID);
      oe_seen = 1'b0;
      cmd(8'h77, 2, 0);
      chk("unknown_oe", 8'h00, {7'h00, oe_seen});
   endtask : t_reads
   task t_program;
      cmd(OP_WRITE_ENABLE, 0, 0);
      sfid_host_inst.start;
      sfid_host_inst.xbyte(OP_PAGE_PROGRAM, rx);
      sfid_host_inst.xbyte(8'h00, rx);
      sfid_host_inst.xbyte(8'h01, rx);
      sfid_host_inst.xbyte(8'hfe, rx);
      for (int i = 1; i <= 3; i++)
         sfid_host_inst.xbyte(8'(i * 8'h11), rx);
      sfid_host_inst.stop;
      chk("pp_off", 8'h00, last_off);
      chk("pp_dat", 8'h33, last_dat);
      chk("pp_addr", 8'h01, op_addr[15:8]);
      chk("pp_code", OP_PAGE_PROGRAM, op_code);
      chk("pp_busy", 8'h9f, status_byte);
      er(OP_PAGE_PROGRAM, 0, 0, 1'b0, 8'h01);
   endtask : t_program
   task t_erase;
      er(OP_SECTOR_ERASE, 3, 0, 1'b0, 8'h01);
      er(OP_SECTOR_ERASE, 3, 0, 1'b1, 8'h02);
      er(OP_BLOCK_ERASE, 3, 0, 1'b1, 8'h03);
      er(OP_CHIP_ERASE_A, 0, 0, 1'b1, 8'h04);
      er(OP_CHIP_ERASE_B, 0, 3, 1'b1, 8'h04);
      er(OP_CHIP_ERASE_B, 0, 0, 1'b0, 8'h05);
   endtask : t_erase

   initial
   begin
      op_done = 1'b0;
      repeat (12) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge core_clk);
      #7;
      chk("reset", 8'h00, status_byte);
      t_status_write;
      t_reads;
      t_program;
      t_erase;
      conclude;
   end
endmodule : sfid_top_test
`default_nettype wire
